/* rtl/dpsc_pkg.sv */
// Package for the dual-port static RAM host port controller.
// Assumes a 100 MHz clock; all pin timing is expressed in cycles of it.
package dpsc_pkg;
   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int DPSC_ADDR_W = 11;
   localparam int DPSC_DATA_W = 16;
   localparam int DPSC_BYTE_W = 8;
   localparam int DPSC_CLK_NS = 10;

   // ----------------------------------------
   // Timing figures in ns, fastest grade
   // ----------------------------------------
   localparam int FLAG_ACCESS_FROM_ADDRESS_NS = 25;
   localparam int WRITE_PULSE_NS = 20;
   localparam int WRITE_RECOVERY_TIME_NS = 0;
   localparam int ADDR_SETUP_NS = 0;
   localparam int DATA_HOLD_TIME_NS = 0;
   localparam int WRITE_ENABLE_TO_HIGHZ_NS = 15;
   localparam int DATA_VALID_TO_END_NS = 15;
   localparam int WRITE_TO_FLAG_TIME_NS = 0;
   localparam int WRITE_HOLD_AFTER_FLAG_NS = 20;
   localparam int READ_CYCLE_NS = 25;
   localparam int PRIORITY_SETUP_NS = 5;

   // ----------------------------------------
   // Derived cycle counts (least times round up, at least one)
   // ----------------------------------------
   function automatic int dpsc_min_cyc(input int ns);
      int c;
      c = (ns + DPSC_CLK_NS - 1) / DPSC_CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int WP_PLAIN_NS = WRITE_PULSE_NS;
   localparam int WP_OE_NS = (WRITE_ENABLE_TO_HIGHZ_NS + DATA_VALID_TO_END_NS > WRITE_PULSE_NS) ?
      WRITE_ENABLE_TO_HIGHZ_NS + DATA_VALID_TO_END_NS : WRITE_PULSE_NS;
   localparam int WP_CYC = dpsc_min_cyc(WP_PLAIN_NS);
   localparam int WP_OE_CYC = dpsc_min_cyc(WP_OE_NS);
   localparam int SETUP_CYC = dpsc_min_cyc(FLAG_ACCESS_FROM_ADDRESS_NS + WRITE_TO_FLAG_TIME_NS);
   localparam int REC_CYC = dpsc_min_cyc(WRITE_RECOVERY_TIME_NS + DATA_HOLD_TIME_NS);
   localparam int HOLD_CYC = dpsc_min_cyc(WRITE_HOLD_AFTER_FLAG_NS);
   localparam int RD_CYC = dpsc_min_cyc(READ_CYCLE_NS);
   localparam int PRIO_CYC = dpsc_min_cyc(PRIORITY_SETUP_NS);
   localparam int WR_CYCLE_NS = FLAG_ACCESS_FROM_ADDRESS_NS + WRITE_RECOVERY_TIME_NS + WRITE_PULSE_NS;
   localparam int WR_CYCLE_CYC = dpsc_min_cyc(WR_CYCLE_NS);
   localparam int CNT_W = 4;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [2:0] {
      DPSC_IDLE, DPSC_SETUP, DPSC_PULSE, DPSC_HOLD, DPSC_RECOVER, DPSC_READ
   } dpsc_state_e;

   typedef struct packed {
      logic write;
      logic [1:0] byte_en;
      logic [DPSC_ADDR_W-1:0] addr;
      logic [DPSC_DATA_W-1:0] wdata;
   } dpsc_req_s;

   typedef struct packed {
      logic select_n;
      logic out_enable_n;
      logic lower_byte_write_n;
      logic upper_byte_write_n;
      logic [DPSC_ADDR_W-1:0] addr;
   } dpsc_pins_s;
endpackage

/* rtl/dpsc_cycle_timer.sv */
// Down-counter that times one phase of a port access.
// Assumes the caller loads it on every phase change.
`timescale 1ns/1ps
module dpsc_cycle_timer (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [dpsc_pkg::CNT_W-1:0] value,
   output logic done
);
   import dpsc_pkg::*;
   logic [CNT_W-1:0] cnt_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= '0;
      end else if (load) begin
         cnt_q <= value;
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end

   // Done looks at the count alone: the sequencer loads on done, so no loop forms
   assign done = (cnt_q == '0);
endmodule

/* rtl/dpsc_port_host.sv */
// Host controller for one port of a 2K x 16 dual-port static RAM.
// Assumes pins are synchronous to clk and the contention flag is wired in.
`timescale 1ns/1ps
module dpsc_port_host (
   input wire logic clk,
   input wire logic reset_n,
   input wire dpsc_pkg::dpsc_req_s req,
   input wire logic req_valid,
   output logic req_ready,
   output logic [dpsc_pkg::DPSC_DATA_W-1:0] rdata,
   output logic rdata_valid,
   input wire logic oe_during_write,
   output dpsc_pkg::dpsc_pins_s pins,
   input wire logic [dpsc_pkg::DPSC_DATA_W-1:0] data_in,
   output logic [dpsc_pkg::DPSC_DATA_W-1:0] data_out,
   output logic [1:0] data_oe,
   input wire logic contention_flag_n
);
   import dpsc_pkg::*;

   // ----------------------------------------
   // State
   // ----------------------------------------
   dpsc_state_e state_q, state_d;
   dpsc_req_s req_q;
   logic oe_wr_q;
   logic flag_seen_q;
   logic tmr_load;
   logic [CNT_W-1:0] tmr_value;
   logic tmr_done;

   function automatic logic [CNT_W-1:0] to_cnt(input int cyc);
      return CNT_W'(cyc - 1);
   endfunction

   dpsc_cycle_timer u_timer (
      .clk(clk),
      .reset_n(reset_n),
      .load(tmr_load),
      .value(tmr_value),
      .done(tmr_done)
   );

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      tmr_load = 1'b0;
      tmr_value = '0;
      case (state_q)
         DPSC_IDLE: begin
            if (req_valid) begin
               tmr_load = 1'b1;
               tmr_value = req.write ? to_cnt(SETUP_CYC) : to_cnt(RD_CYC + PRIO_CYC);
               state_d = req.write ? DPSC_SETUP : DPSC_READ;
            end
         end
         DPSC_SETUP: begin
            if (tmr_done && contention_flag_n) begin
               tmr_load = 1'b1;
               tmr_value = oe_wr_q ? to_cnt(WP_OE_CYC) : to_cnt(WP_CYC);
               state_d = DPSC_PULSE;
            end
         end
         DPSC_PULSE: begin
            if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_value = to_cnt(flag_seen_q ? HOLD_CYC : 1);
               state_d = DPSC_HOLD;
            end
         end
         DPSC_HOLD: begin
            if (!contention_flag_n) begin
               tmr_load = 1'b1;
               tmr_value = to_cnt(HOLD_CYC);
            end else if (tmr_done) begin
               tmr_load = 1'b1;
               tmr_value = to_cnt(REC_CYC);
               state_d = DPSC_RECOVER;
            end
         end
         DPSC_RECOVER: begin
            if (tmr_done) begin
               state_d = DPSC_IDLE;
            end
         end
         DPSC_READ: begin
            if (!contention_flag_n) begin
               tmr_load = 1'b1;
               tmr_value = to_cnt(RD_CYC);
            end else if (tmr_done) begin
               state_d = DPSC_IDLE;
            end
         end
         default: begin
            state_d = DPSC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= DPSC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   assign req_ready = (state_q == DPSC_IDLE);

   // ----------------------------------------
   // Request capture
   // ----------------------------------------
   // address only moves while idle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         req_q <= '0;
         oe_wr_q <= 1'b0;
      end else if (req_valid && req_ready) begin
         req_q <= req;
         oe_wr_q <= oe_during_write;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag_seen_q <= 1'b0;
      end else if (state_q == DPSC_IDLE) begin
         flag_seen_q <= 1'b0;
      end else if (!contention_flag_n) begin
         flag_seen_q <= 1'b1;
      end
   end

   function automatic logic tmr_done_hold();
      return (state_q == DPSC_HOLD) && contention_flag_n && tmr_done;
   endfunction

   // ----------------------------------------
   // Pins
   // ----------------------------------------
   // Select stays low across the whole write so only the write lines shape the pulse.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pins <= '{select_n: 1'b1, out_enable_n: 1'b1, lower_byte_write_n: 1'b1,
                   upper_byte_write_n: 1'b1, addr: '0};
      end else begin
         pins.addr <= (state_d == DPSC_IDLE) ? pins.addr : req_valid && req_ready ? req.addr : req_q.addr;
         pins.select_n <= (state_d == DPSC_IDLE);
         pins.out_enable_n <= !((state_d == DPSC_READ) || (state_d == DPSC_PULSE && oe_wr_q));
         pins.lower_byte_write_n <= !((state_d == DPSC_PULSE || (state_d == DPSC_HOLD && !tmr_done_hold()))
                                      && req_q.byte_en[0]);
         pins.upper_byte_write_n <= !((state_d == DPSC_PULSE || (state_d == DPSC_HOLD && !tmr_done_hold()))
                                      && req_q.byte_en[1]);
      end
   end

   // data held through recovery
   // Lanes drive from the edge the write lines fall, so data stands the whole pulse
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         data_out <= '0;
         data_oe <= 2'h0;
      end else begin
         data_out <= req_q.wdata;
         data_oe <= (state_d == DPSC_PULSE || state_d == DPSC_HOLD || state_d == DPSC_RECOVER) ?
                    req_q.byte_en : 2'h0;
      end
   end

   // ----------------------------------------
   // Read return
   // ----------------------------------------
   // read window covers port delay
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata <= '0;
         rdata_valid <= 1'b0;
      end else begin
         rdata_valid <= (state_q == DPSC_READ) && tmr_done && contention_flag_n;
         if ((state_q == DPSC_READ) && tmr_done && contention_flag_n) begin
            rdata <= data_in;
         end
      end
   end
endmodule

/* test/dpsc_ram_model.sv */
// Behavioural model of one port of the dual-port memory.
// Assumes the bench commands the contention flag through busy_on.
`timescale 1ns/1ps
module dpsc_ram_model (
   input wire logic clk,
   input wire dpsc_pkg::dpsc_pins_s pins,
   input wire logic [15:0] data_out,
   input wire logic [1:0] data_oe,
   input wire logic busy_on,
   output logic [15:0] data_in,
   output logic contention_flag_n
);
   import dpsc_pkg::*;
   logic [15:0] mem [0:2047];
   logic [15:0] last_q = 16'h5A5A;
   logic drive;
   realtime rel_t = 0.0;
   assign contention_flag_n = ~busy_on;
   always @(posedge contention_flag_n) rel_t = $realtime;
   assign drive = !pins.select_n && !pins.out_enable_n && pins.lower_byte_write_n
      && pins.upper_byte_write_n && contention_flag_n;
   assign data_in = drive ? mem[pins.addr] : ~last_q;
   // Released bus toggles so a stale value never passes
   always @(posedge clk) last_q <= data_in;
   function automatic logic wr_ok();
      return !pins.select_n && contention_flag_n && ($realtime - rel_t >= WRITE_HOLD_AFTER_FLAG_NS);
   endfunction
   always @(posedge pins.lower_byte_write_n) if (wr_ok()) mem[pins.addr][7:0] = data_oe[0] ? data_out[7:0] : 'x;
   always @(posedge pins.upper_byte_write_n) if (wr_ok()) mem[pins.addr][15:8] = data_oe[1] ? data_out[15:8] : 'x;
endmodule

/* test/dpsc_port_host_sva.sv */
// Assertions on the memory pins of one host port.
// Assumes it is bound onto dpsc_port_host.
`timescale 1ns/1ps
module dpsc_port_host_sva (
   input wire logic clk,
   input wire logic reset_n,
   input wire dpsc_pkg::dpsc_pins_s pins,
   input wire logic [1:0] data_oe,
   input wire logic rdata_valid,
   input wire logic contention_flag_n
);
   import dpsc_pkg::*;
   logic lw, uw, sel;
   assign lw = pins.lower_byte_write_n;
   assign uw = pins.upper_byte_write_n;
   assign sel = pins.select_n;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_WR_NEEDS_SEL: assert property (!lw || !uw |-> !sel)
      else $error("write line low while deselected");
   AST_ADDR_HELD: assert property (!sel && !$past(sel) |-> $stable(pins.addr))
      else $error("address moved inside access");
   AST_SEL_FIRST: assert property ($fell(lw) || $fell(uw) |-> !$past(sel))
      else $error("select did not lead write");
   AST_FLAG_SETUP: assert property ($fell(lw) || $fell(uw) |-> !$past(sel, 3))
      else $error("pulse before flag access time");
   AST_OE_PULSE: assert property ($fell(lw) && !pins.out_enable_n |-> !lw [*3])
      else $error("pulse short with output enable low");
   AST_UP_PULSE: assert property ($fell(uw) |-> !uw [*2])
      else $error("upper pulse short");
   AST_PULSE_FLAG: assert property ($fell(lw) || $fell(uw) |-> $past(contention_flag_n))
      else $error("pulse started under flag");
   AST_HOLD_FLAG: assert property ($rose(contention_flag_n) && !lw |-> !lw [*2])
      else $error("pulse ended too soon after flag");
   AST_DATA_HOLD: assert property ($rose(lw) |-> data_oe[0])
      else $error("data dropped at end of write");
   AST_READ_QUIET: assert property (!sel && data_oe == 2'h0 |-> lw && uw)
      else $error("write line low while not driving");
   cover property (rdata_valid);
   cover property ($fell(lw) && !pins.out_enable_n);
   cover property ($rose(contention_flag_n) && !lw);
endmodule
bind dpsc_port_host dpsc_port_host_sva chk_u (.clk(clk), .reset_n(reset_n), .pins(pins), .data_oe(data_oe),
   .rdata_valid(rdata_valid), .contention_flag_n(contention_flag_n));

/* test/dual_port_sram_access_busy_bench.sv */
// Self-checking bench for one host port against the memory model.
// Assumes the model stands in for the memory and its flag.
`timescale 1ns/1ps
module dual_port_sram_access_busy_bench;
   import dpsc_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   dpsc_req_s req = '0;
   logic req_valid = 1'b0;
   logic oe_during_write = 1'b0;
   logic busy_on = 1'b0;
   logic req_ready, rdata_valid, contention_flag_n;
   logic [15:0] rdata, data_in, data_out;
   logic [1:0] data_oe;
   dpsc_pins_s pins;
   int fails = 0;
   int checked = 0;
   int cyc = 0;
   dpsc_port_host dut_u (.clk(clk), .reset_n(reset_n), .req(req), .req_valid(req_valid), .req_ready(req_ready),
      .rdata(rdata), .rdata_valid(rdata_valid), .oe_during_write(oe_during_write), .pins(pins),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .contention_flag_n(contention_flag_n));
   dpsc_ram_model ram_u (.clk(clk), .pins(pins), .data_out(data_out), .data_oe(data_oe), .busy_on(busy_on),
      .data_in(data_in), .contention_flag_n(contention_flag_n));
   initial begin
      forever #5 clk = ~clk;
   end
   // Whole run needs under two hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         complete_run();
      end
   end
   task complete_run();
      if (fails == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task issue(input logic w, input logic [1:0] be, input logic [10:0] a, input logic [15:0] d, input logic oe);
      do @(negedge clk); while (req_ready !== 1'b1);
      @(posedge clk);
      req <= '{write: w, byte_en: be, addr: a, wdata: d};
      oe_during_write <= oe;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
   endtask
   task rd(input logic [10:0] a, input logic [15:0] exp);
      int n;
      issue(1'b0, 2'h0, a, 16'h0, 1'b0);
      n = 0;
      while (rdata_valid !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      chk(rdata_valid === 1'b1 ? rdata : ~exp, exp);
   endtask
   task s_plain();
      issue(1'b1, 2'h3, 11'h7FF, 16'h1234, 1'b0);
      issue(1'b1, 2'h3, 11'h000, 16'hABCD, 1'b0);
      rd(11'h7FF, 16'h1234);
      rd(11'h000, 16'hABCD);
   endtask
   task s_lanes();
      issue(1'b1, 2'h1, 11'h7FF, 16'hBBEE, 1'b0);
      rd(11'h7FF, 16'h12EE);
      issue(1'b1, 2'h2, 11'h7FF, 16'h55AA, 1'b0);
      rd(11'h7FF, 16'h55EE);
      issue(1'b1, 2'h0, 11'h7FF, 16'hFFFF, 1'b0);
      rd(11'h7FF, 16'h55EE);
   endtask
   task s_oe();
      issue(1'b1, 2'h3, 11'h123, 16'hC3C3, 1'b1);
      rd(11'h123, 16'hC3C3);
   endtask
   task s_busy_write();
      @(posedge clk);
      busy_on <= 1'b1;
      issue(1'b1, 2'h3, 11'h055, 16'h0F0F, 1'b0);
      repeat (4) @(negedge clk);
      chk({14'h0, pins.lower_byte_write_n, pins.upper_byte_write_n}, 16'h0003);
      repeat (4) @(negedge clk);
      chk({14'h0, pins.lower_byte_write_n, pins.upper_byte_write_n}, 16'h0003);
      @(posedge clk);
      busy_on <= 1'b0;
      rd(11'h055, 16'h0F0F);
   endtask
   task s_busy_pulse();
      int n;
      issue(1'b1, 2'h3, 11'h056, 16'hF00F, 1'b0);
      n = 0;
      while (pins.lower_byte_write_n !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      @(posedge clk);
      busy_on <= 1'b1;
      repeat (3) @(posedge clk);
      busy_on <= 1'b0;
      rd(11'h056, 16'hF00F);
   endtask
   task s_busy_read();
      @(posedge clk);
      busy_on <= 1'b1;
      fork
         rd(11'h056, 16'hF00F);
         begin
            repeat (8) @(posedge clk);
            busy_on <= 1'b0;
         end
      join
   endtask
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      s_plain();
      s_lanes();
      s_oe();
      s_busy_write();
      s_busy_pulse();
      s_busy_read();
      complete_run();
   end
endmodule
